//--- itm_master.v
// Summary of operation
// - serial clock period is exactly 1024 core clock cycles.
// - serial clock high phase lasts exactly 512 cycles.
// - serial clock low phase lasts exactly 512 cycles.
// - stop: clock high 512 cycles before data line is released.
// - bus idle at least 512 cycles after stop before next start.
// - clock held high at least 1024 cycles before a start.
// - data low for start, then 512 cycles before clock goes low.
// - new outgoing bit appears 256 cycles into the clock low phase.
// - outgoing bit held 256 cycles after the falling edge ending it.
// - incoming data and acknowledge sampled 256 cycles after rising edge.
`timescale 1ns/1ns
`default_nettype none
`include "itm_defines.vh"
module itm_master #(
  parameter CNT_W = `ITM_CNT_W
) (
  input wire core_clk,
  input wire rst,
  input wire bit_valid,
  output wire bit_ready,
  input wire bit_start,
  input wire bit_stop,
  input wire bit_data,
  output reg rx_valid_q,
  output reg rx_data_q,
  output wire busy,
  input wire scl_in,
  output wire scl_out,
  output reg scl_oe_q,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_q
);
  // ----------------------------------------------------------------
  // states and constants
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SETUP = 3'd1;
  localparam [2:0] ST_START = 3'd2;
  localparam [2:0] ST_LOW = 3'd3;
  localparam [2:0] ST_HIGH = 3'd4;
  localparam [2:0] ST_PSTOP = 3'd5;
  localparam [2:0] ST_STOP = 3'd6;
  localparam [2:0] ST_FREE = 3'd7;
  // counts are worked out at full integer width, then cut to the
  // counter width on purpose; every count fits below 2**CNT_W
  localparam integer HALF_I = `ITM_HALF_CYCLES - 1;
  localparam integer QTR_I = `ITM_QUARTER_CYCLES;
  localparam integer SETUP_I = `ITM_START_SETUP_CYCLES - 1;
  localparam integer FREE_I = `ITM_BUS_FREE_CYCLES - 1;
  localparam [CNT_W-1:0] HALF_M1 = HALF_I[CNT_W-1:0];
  localparam [CNT_W-1:0] QTR = QTR_I[CNT_W-1:0];
  localparam [CNT_W-1:0] SETUP_M1 = SETUP_I[CNT_W-1:0];
  localparam [CNT_W-1:0] FREE_M1 = FREE_I[CNT_W-1:0];

  reg [2:0] state_q;
  reg [CNT_W-1:0] cnt_q;
  reg cur_data_q;
  reg nxt_data_q;
  reg nxt_stop_q;
  reg have_bit_q;
  wire [1:0] pins_sync;
  wire sda_sync;
  wire take;

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  itm_sync2 #(.W(2)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({scl_in, sda_in}),
    .sync_q(pins_sync)
  );
  assign sda_sync = pins_sync[0];

  // ----------------------------------------------------------------
  // pin drivers and handshake
  // ----------------------------------------------------------------
  // open-drain: only ever drive low, release otherwise
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign busy = (state_q != ST_IDLE);
  // one bit may be queued while the previous one is still on the wire
  assign bit_ready = !have_bit_q && (state_q == ST_IDLE || state_q == ST_LOW ||
    state_q == ST_HIGH || state_q == ST_START);
  // in idle only a start request is taken; a lone data bit there would
  // sit queued forever and block every later request
  assign take = bit_valid && bit_ready && (bit_start || state_q != ST_IDLE);

  // ----------------------------------------------------------------
  // phase engine
  // ----------------------------------------------------------------
  // scl_in is synchronised but not used to stretch: the phases are
  // fixed counts, so clock stretching by the slave is not supported
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= {CNT_W{1'b0}};
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cur_data_q <= 1'b1;
      nxt_data_q <= 1'b1;
      nxt_stop_q <= 1'b0;
      have_bit_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      if (take)
      begin
        have_bit_q <= 1'b1;
        nxt_data_q <= bit_data;
        nxt_stop_q <= bit_stop;
      end
      case (state_q)
        ST_IDLE:
        begin
          cnt_q <= {CNT_W{1'b0}};
          if (bit_valid && bit_start)
            state_q <= ST_SETUP;
        end
        // clock stays released through the whole setup count
        ST_SETUP:
          if (cnt_q == SETUP_M1)
          begin
            sda_oe_q <= 1'b1;
            cnt_q <= {CNT_W{1'b0}};
            state_q <= ST_START;
          end
        ST_START:
          if (cnt_q == HALF_M1)
          begin
            scl_oe_q <= 1'b1;
            cnt_q <= {CNT_W{1'b0}};
            state_q <= ST_LOW;
          end
        ST_LOW:
        begin
          if (cnt_q == QTR - 1'b1 && have_bit_q)
          begin
            have_bit_q <= 1'b0;
            if (nxt_stop_q)
            begin
              // stop takes the place of a data bit: pull the data line
              // low under the low clock so its release is a clean stop
              sda_oe_q <= 1'b1;
              state_q <= ST_PSTOP;
            end
            else
            begin
              cur_data_q <= nxt_data_q;
              sda_oe_q <= !nxt_data_q;
            end
          end
          if (cnt_q == HALF_M1 && state_q == ST_LOW)
          begin
            scl_oe_q <= 1'b0;
            cnt_q <= {CNT_W{1'b0}};
            state_q <= ST_HIGH;
          end
          else if (cnt_q == HALF_M1)
          begin
            scl_oe_q <= 1'b0;
            cnt_q <= {CNT_W{1'b0}};
            state_q <= ST_STOP;
          end
        end
        ST_PSTOP:
          if (cnt_q == HALF_M1)
          begin
            scl_oe_q <= 1'b0;
            cnt_q <= {CNT_W{1'b0}};
            state_q <= ST_STOP;
          end
        ST_HIGH:
        begin
          // the synchronised pin lags the wire by two cycles, which is
          // negligible against a quarter period
          if (cnt_q == QTR - 1'b1)
          begin
            rx_valid_q <= 1'b1;
            rx_data_q <= sda_sync;
          end
          if (cnt_q == HALF_M1)
          begin
            scl_oe_q <= 1'b1;
            cnt_q <= {CNT_W{1'b0}};
            state_q <= ST_LOW;
          end
        end
        ST_STOP:
          if (cnt_q == HALF_M1)
          begin
            sda_oe_q <= 1'b0;
            cnt_q <= {CNT_W{1'b0}};
            state_q <= ST_FREE;
          end
        // both lines released; no new start before the free time ends
        ST_FREE:
          if (cnt_q == FREE_M1)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- itm_defines.vh
`ifndef ITM_DEFINES_VH
`define ITM_DEFINES_VH
// serial bus phase lengths, in core_clk cycles
`define ITM_HALF_CYCLES 512
`define ITM_PERIOD_CYCLES 1024
`define ITM_QUARTER_CYCLES 256
`define ITM_START_SETUP_CYCLES 1024
`define ITM_BUS_FREE_CYCLES 512
`define ITM_CNT_W 11
`endif

//--- itm_sync2.v
`timescale 1ns/1ns
`default_nettype none
module itm_sync2 #(
  parameter W = 2
) (
  input wire core_clk,
  input wire rst,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_q
);
  reg [W-1:0] meta_q;
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- itm_master_chk.sv
`timescale 1ns/1ns
`default_nettype none
module itm_master_chk (
  input wire logic core_clk, rst, rx_valid_q, scl_out, scl_oe_q, sda_out, sda_oe_q
);
  logic s_q, d_q;
  int n_q, m_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // cycles since each enable last moved
  always @(posedge core_clk)
  begin
    s_q <= scl_oe_q;
    d_q <= sda_oe_q;
    n_q <= (rst || scl_oe_q != s_q) ? 0 : n_q + 1;
    m_q <= (rst || sda_oe_q != d_q) ? 0 : m_q + 1;
  end
  a_low_len: assert property (s_q && !scl_oe_q |-> n_q == 511)
    else $error("low len");
  // the high before a start is long, any other is one half period
  a_high_len: assert property (!s_q && scl_oe_q |-> n_q == 511 || n_q > 1534)
    else $error("high len");
  a_start_setup: assert property ($rose(sda_oe_q) && !scl_oe_q |-> n_q >= 1023)
    else $error("start setup");
  a_start_hold: assert property ($rose(sda_oe_q) && !scl_oe_q |-> ##[512:512] $rose(scl_oe_q))
    else $error("start hold");
  a_stop_setup: assert property ($fell(sda_oe_q) && !scl_oe_q |-> n_q == 511)
    else $error("stop setup");
  a_bus_free: assert property ($rose(sda_oe_q) && !scl_oe_q |-> m_q >= 511)
    else $error("bus free");
  a_data_launch: assert property (scl_oe_q && sda_oe_q != d_q |-> n_q == 255)
    else $error("data launch");
  a_sample_pt: assert property (rx_valid_q |-> !scl_oe_q && n_q == 255)
    else $error("sample point");
  a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("line driven high");
endmodule
bind itm_master itm_master_chk i_chk (.core_clk, .rst, .rx_valid_q, .scl_out, .scl_oe_q,
  .sda_out, .sda_oe_q);
`default_nettype wire

//--- itm_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module itm_slave_model (
  input wire logic scl, sda, ack_en,
  output logic pull
);
  int k = 0;
  initial pull = 1'b0;
  always @(negedge sda) if (scl) k = 0;
  // only ever pulls low, the ninth bit as acknowledge
  always @(negedge scl)
  begin
    k = k + 1;
    pull = ack_en && k == 9;
  end
endmodule
`default_nettype wire

//--- itm_master_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module itm_master_tb_top;
  logic core_clk = 0, rst = 1, bit_valid = 0, bit_start = 0, bit_stop = 0, bit_data = 0;
  logic ack_en = 0, pull;
  wire logic bit_ready, rx_valid_q, rx_data_q, busy, scl_out, scl_oe_q, sda_out, sda_oe_q;
  wire logic scl = !scl_oe_q;
  wire logic sda = !(sda_oe_q || pull);
  int fail_count = 0, n_tests = 0, cyc = 0;
  logic q[$];
  itm_master i_dut (.core_clk, .rst, .bit_valid, .bit_ready, .bit_start, .bit_stop, .bit_data,
    .rx_valid_q, .rx_data_q, .busy, .scl_in(scl), .scl_out, .scl_oe_q, .sda_in(sda), .sda_out,
    .sda_oe_q);
  itm_slave_model i_slv (.scl, .sda, .ack_en, .pull);
  initial forever #10 core_clk = ~core_clk;
  task chk(input logic g, e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task put(input logic s, p, d);
    @(negedge core_clk);
    {bit_valid, bit_start, bit_stop, bit_data} = {1'b1, s, p, d};
    while (bit_ready !== 1'b1)
      @(negedge core_clk);
    @(negedge core_clk);
    bit_valid = 0;
  endtask
  task reset_state;
    chk(scl_oe_q, 0);
    chk(sda_oe_q, 0);
    chk(bit_ready, 1);
  endtask
  task frame(input logic [7:0] b, input logic a);
    q.delete();
    ack_en = a;
    put(1, 0, b[7]);
    for (int i = 6; i >= 0; i--)
      put(0, 0, b[i]);
    put(0, 0, 1);
    put(0, 1, 0);
    while (busy !== 1'b0)
      @(negedge core_clk);
    for (int i = 0; i < 8; i++)
      chk(q[i], b[7 - i]);
    chk(q[8], !a);
  endtask
  task abort_frame;
    put(1, 0, 0);
    repeat (1500) @(negedge core_clk);
    chk(scl_oe_q, 0);
    repeat (100) @(negedge core_clk);
    chk(scl_oe_q, 1);
    rst = 1;
    repeat (6) @(negedge core_clk);
    rst = 0;
    reset_state();
  endtask
  always @(negedge core_clk)
  begin
    cyc <= cyc + 1;
    if (rx_valid_q === 1'b1)
      q.push_back(rx_data_q);
    if (cyc == 60000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (6) @(negedge core_clk);
    rst = 0;
    reset_state();
    frame(8'hA5, 1);
    frame(8'h3C, 0);
    abort_frame();
    frame(8'h81, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
